// >>> qrp_pkg.sv
// Shared constants and types of the quad I/O read path.
package qrp_pkg;

    // ==========================================================
    // Command codes
    // ==========================================================
    localparam logic [7:0] OP_QUAD_READ = 8'hEB;
    localparam logic [7:0] OP_WORD_READ = 8'hE7;
    localparam logic [7:0] OP_OCTAL_READ = 8'hE3;

    // ==========================================================
    // Phase lengths in link clocks
    // ==========================================================
    localparam logic [3:0] SPI_CMD_CLKS = 4'h8;
    localparam logic [3:0] QPI_CMD_CLKS = 4'h2;
    localparam logic [3:0] ADDR_CLKS = 4'h6;
    localparam logic [3:0] MODE_CLKS = 4'h2;
    localparam logic [3:0] WORD_DUMMY_CLKS = 4'h2;
    localparam logic [3:0] OCTAL_DUMMY_CLKS = 4'h0;
    localparam int QUAD_DUMMY_CLKS_DEF = 4;

    // ==========================================================
    // Field positions and reset values
    // ==========================================================
    localparam logic [1:0] CONT_SKIP_SEL = 2'h2;
    localparam int CONT_SEL_LSB = 4;
    localparam int WRAP_BYTE_LSB = 4;
    localparam int WRAP_DIS_POS = 0;
    localparam int WRAP_LEN_LSB = 1;
    localparam logic [2:0] WRAP_RESET = 3'h1;
    localparam logic [1:0] DUMMY_SEL_RESET = 2'h0;
    localparam logic [7:0] CONT_BITS_RESET = 8'h00;
    localparam logic [6:0] WRAP_BASE_LEN = 7'h08;

    // ==========================================================
    // Types
    // ==========================================================
    typedef enum logic [5:0] {
        ST_START = 6'h01,
        ST_CMD = 6'h02,
        ST_ADDR = 6'h04,
        ST_MODE = 6'h08,
        ST_DUMMY = 6'h10,
        ST_DATA = 6'h20
    } qrp_state_e;

    typedef enum logic [1:0] {
        RD_NONE = 2'h0,
        RD_QUAD = 2'h1,
        RD_WORD = 2'h2,
        RD_OCTAL = 2'h3
    } qrp_kind_e;

    typedef struct packed {
        logic quadEnable;
        logic fourWire;
        logic [2:0] wrapSetting;
        logic [1:0] dummySel;
    } qrp_cfg_s;

endpackage

// >>> qrp_quad_io_read_path.sv
// Quad I/O read path of a serial NOR flash, device side.
`timescale 1ns/10ps

module qrp_quad_io_read_path #(
    parameter int QUAD_DUMMY_CLKS = qrp_pkg::QUAD_DUMMY_CLKS_DEF
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic quadEnable,
    input wire logic fourWireMode,
    input wire logic wrapLoad,
    input wire logic [7:0] wrapByte,
    input wire logic readParamLoad,
    input wire logic [1:0] readParam,
    input wire logic softReset,
    input wire logic contModeReset,
    output logic contModeActive,
    output logic [2:0] wrapSettingBits,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic [3:0] ioIn,
    output logic [3:0] ioOut,
    output logic [3:0] ioOe,
    output logic [23:0] memAddr,
    input wire logic [7:0] memData
);

    // ==========================================================
    // Elaboration checks
    // ==========================================================
    // The dummy counter is four bits wide and a zero count has no phase.
    if (QUAD_DUMMY_CLKS < 1 || QUAD_DUMMY_CLKS > 15) begin : gBadDummy
        $error("QUAD_DUMMY_CLKS must lie between 1 and 15");
    end

    // ==========================================================
    // Functions
    // ==========================================================
    // True on the last clock of a phase of the given length.
    function automatic logic lastClk(input logic [3:0] cnt, input logic [3:0] len);
        lastClk = (cnt == 4'(len - 4'h1));
    endfunction

    // Next read address, kept inside an aligned section when wrapping.
    function automatic logic [23:0] advance(input logic [23:0] a, input logic wrap,
                                            input logic [1:0] len);
        logic [23:0] mask;
        logic [23:0] inc;
        mask = {18'h0_0000, 6'((qrp_pkg::WRAP_BASE_LEN << len) - 7'h01)};
        inc = a + 24'h00_0001;
        if (wrap) begin
            advance = (a & ~mask) | (inc & mask);
        end else begin
            advance = inc;
        end
    endfunction

    // ==========================================================
    // Reference domain: stored settings
    // ==========================================================
    qrp_pkg::qrp_cfg_s cfg;
    logic contResetTgl;
    logic [2:0] next_wrapSetting;
    logic [1:0] next_dummySel;
    logic actMeta;
    logic contSkip;

    // A software reset restores the defaults and wins over a load in the same cycle.
    // top bit dropped
    assign next_wrapSetting = softReset ? qrp_pkg::WRAP_RESET :
                              wrapLoad ? wrapByte[qrp_pkg::WRAP_BYTE_LSB +: 3] :
                              cfg.wrapSetting;
    assign next_dummySel = softReset ? qrp_pkg::DUMMY_SEL_RESET :
                           readParamLoad ? readParam : cfg.dummySel;

    // Settings registers; the continuous mode bits are not touched here.
    // software reset spares
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg <= '{1'b0, 1'b0, qrp_pkg::WRAP_RESET, qrp_pkg::DUMMY_SEL_RESET};
            contResetTgl <= 1'b0;
        end else begin
            cfg <= '{quadEnable, fourWireMode, next_wrapSetting, next_dummySel};
            contResetTgl <= contResetTgl ^ contModeReset;
        end
    end

    // Continuous mode status comes back from the link through two flip-flops.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            actMeta <= 1'b0;
            contModeActive <= 1'b0;
            wrapSettingBits <= qrp_pkg::WRAP_RESET;
        end else begin
            actMeta <= contSkip;
            contModeActive <= actMeta;
            wrapSettingBits <= next_wrapSetting;
        end
    end

    // ==========================================================
    // Link domain: crossing of settings and mode reset event
    // ==========================================================
    qrp_pkg::qrp_cfg_s cfgMeta;
    qrp_pkg::qrp_cfg_s cfgLink;
    logic tglMeta;
    logic tglLink;
    logic tglSeen;

    // Settings are quasi-static, so a plain two-stage sync per bit is enough.
    // A change only lands once the link clock has run two edges, so it should
    // be made between frames, a frame or two ahead of its first use.
    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            cfgMeta <= '{1'b0, 1'b0, qrp_pkg::WRAP_RESET, qrp_pkg::DUMMY_SEL_RESET};
            cfgLink <= '{1'b0, 1'b0, qrp_pkg::WRAP_RESET, qrp_pkg::DUMMY_SEL_RESET};
            tglMeta <= 1'b0;
            tglLink <= 1'b0;
        end else begin
            cfgMeta <= cfg;
            cfgLink <= cfgMeta;
            tglMeta <= contResetTgl;
            tglLink <= tglMeta;
        end
    end

    // ==========================================================
    // Link domain: decode
    // ==========================================================
    qrp_pkg::qrp_state_e state;
    qrp_pkg::qrp_state_e next_state;
    qrp_pkg::qrp_kind_e kind;
    qrp_pkg::qrp_kind_e contKind;
    qrp_pkg::qrp_kind_e cmdKind;
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic [7:0] cmdShift;
    logic [7:0] contBits;
    logic [3:0] modeHi;
    logic half;
    logic frameRst_n;
    logic clearPending;
    logic [3:0] cmdLen;
    logic [7:0] cmdWord;
    logic [3:0] dummyLen;
    logic wrapOn;
    logic isAddr;
    logic modeDone;

    // Chip select high ends the frame at once, even with the link clock stopped.
    assign frameRst_n = rst_n & ~cs_n;

    // A mode reset that has crossed but is not yet applied already masks the skip.
    // skip on 10
    assign clearPending = (tglLink != tglSeen);
    assign contSkip = (contBits[qrp_pkg::CONT_SEL_LSB +: 2] == qrp_pkg::CONT_SKIP_SEL)
                      & ~clearPending;

    // Command byte comes in one line wide, or four wide in four-wire mode.
    assign cmdLen = cfgLink.fourWire ? qrp_pkg::QPI_CMD_CLKS : qrp_pkg::SPI_CMD_CLKS;
    assign cmdWord = cfgLink.fourWire ? {cmdShift[3:0], ioIn} : {cmdShift[6:0], ioIn[0]};

    // Only the plain quad read is served in four-wire mode.
    // quad enable gate
    assign cmdKind = !cfgLink.quadEnable ? qrp_pkg::RD_NONE :
                     (cmdWord == qrp_pkg::OP_QUAD_READ) ? qrp_pkg::RD_QUAD :
                     cfgLink.fourWire ? qrp_pkg::RD_NONE :
                     (cmdWord == qrp_pkg::OP_WORD_READ) ? qrp_pkg::RD_WORD :
                     (cmdWord == qrp_pkg::OP_OCTAL_READ) ? qrp_pkg::RD_OCTAL :
                     qrp_pkg::RD_NONE;

    // Dummy clocks after the two mode clocks; four-wire counts are twice the read parameter.
    // selectable dummies
    assign dummyLen = (kind == qrp_pkg::RD_WORD) ? qrp_pkg::WORD_DUMMY_CLKS :
                      (kind == qrp_pkg::RD_OCTAL) ? qrp_pkg::OCTAL_DUMMY_CLKS :
                      cfgLink.fourWire ? {1'b0, cfgLink.dummySel, 1'b0} :
                      4'(QUAD_DUMMY_CLKS);

    // Wrapping needs the disable bit low and single-wire command mode.
    // wrap bits
    assign wrapOn = ~cfgLink.wrapSetting[qrp_pkg::WRAP_DIS_POS] & ~cfgLink.fourWire;

    assign isAddr = (state == qrp_pkg::ST_ADDR) | ((state == qrp_pkg::ST_START) & contSkip);
    assign modeDone = (state == qrp_pkg::ST_MODE) & lastClk(cnt, qrp_pkg::MODE_CLKS);

    // ==========================================================
    // Link domain: frame sequencer
    // ==========================================================
    // Unknown commands leave the sequencer parked in the command state,
    // where the counter saturates and the lines stay released.
    always_comb begin
        next_state = state;
        next_cnt = cnt + 4'h1;
        unique case (state)
            qrp_pkg::ST_START: begin
                next_state = contSkip ? qrp_pkg::ST_ADDR : qrp_pkg::ST_CMD;
            end
            qrp_pkg::ST_CMD: begin
                if (cnt == 4'hF) begin
                    next_cnt = cnt;
                end else if (lastClk(cnt, cmdLen) && cmdKind != qrp_pkg::RD_NONE) begin
                    next_state = qrp_pkg::ST_ADDR;
                    next_cnt = 4'h0;
                end
            end
            qrp_pkg::ST_ADDR: begin
                if (lastClk(cnt, qrp_pkg::ADDR_CLKS)) begin
                    next_state = qrp_pkg::ST_MODE;
                    next_cnt = 4'h0;
                end
            end
            qrp_pkg::ST_MODE: begin
                if (modeDone) begin
                    next_state = (dummyLen == 4'h0) ? qrp_pkg::ST_DATA : qrp_pkg::ST_DUMMY;
                    next_cnt = 4'h0;
                end
            end
            qrp_pkg::ST_DUMMY: begin
                if (lastClk(cnt, dummyLen)) begin
                    next_state = qrp_pkg::ST_DATA;
                    next_cnt = 4'h0;
                end
            end
            qrp_pkg::ST_DATA: begin
                next_cnt = cnt;
            end
            default: begin
                next_state = qrp_pkg::ST_CMD;
                next_cnt = 4'hF;
            end
        endcase
    end

    // Frame registers, cleared whenever chip select is high.
    always_ff @(posedge sclk or negedge frameRst_n) begin
        if (!frameRst_n) begin
            state <= qrp_pkg::ST_START;
            cnt <= 4'h0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
        end
    end

    // Command shifter and read kind; a skipped opcode reuses the stored kind.
    // word skip
    always_ff @(posedge sclk or negedge frameRst_n) begin
        if (!frameRst_n) begin
            cmdShift <= 8'h00;
            kind <= qrp_pkg::RD_NONE;
        end else begin
            if (state == qrp_pkg::ST_START || state == qrp_pkg::ST_CMD) begin
                cmdShift <= cmdWord;
            end
            if ((state == qrp_pkg::ST_START) && contSkip) begin
                kind <= contKind;
            end else if ((state == qrp_pkg::ST_CMD) && lastClk(cnt, cmdLen)) begin
                kind <= cmdKind;
            end
        end
    end

    // Address enters a nibble per clock; data advances one byte per two clocks.
    // The address register is not cleared by chip select, it simply reloads.
    // nibble address
    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            memAddr <= 24'h00_0000;
        end else if (isAddr) begin
            memAddr <= {memAddr[19:0], ioIn};
        end else if (state == qrp_pkg::ST_DATA && half) begin
            memAddr <= advance(memAddr, wrapOn, cfgLink.wrapSetting[qrp_pkg::WRAP_LEN_LSB +: 2]);
        end
    end

    // Upper mode nibble is held; the second mode clock is ignored.
    // upper nibble only
    always_ff @(posedge sclk or negedge frameRst_n) begin
        if (!frameRst_n) begin
            modeHi <= 4'h0;
            half <= 1'b0;
        end else begin
            if (state == qrp_pkg::ST_MODE && cnt == 4'h0) begin
                modeHi <= ioIn;
            end
            if (state == qrp_pkg::ST_DATA) begin
                half <= ~half;
            end
        end
    end

    // Continuous mode bits survive chip select and software reset; only power-up
    // reset and the mode reset command clear them. A pending clear wins.
    // ones force exit
    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            contBits <= qrp_pkg::CONT_BITS_RESET;
            contKind <= qrp_pkg::RD_NONE;
            tglSeen <= 1'b0;
        end else if (clearPending) begin
            contBits <= qrp_pkg::CONT_BITS_RESET;
            tglSeen <= tglLink;
        end else if (modeDone) begin
            contBits <= {modeHi, 4'h0};
            contKind <= kind;
        end
    end

    // ==========================================================
    // Link domain: data output on the falling edge
    // ==========================================================
    // High nibble first, then low nibble; lines released outside the data phase.
    // released before data
    always_ff @(negedge sclk or negedge frameRst_n) begin
        if (!frameRst_n) begin
            ioOut <= 4'h0;
            ioOe <= 4'h0;
        end else if (state == qrp_pkg::ST_DATA) begin
            ioOut <= half ? memData[3:0] : memData[7:4];
            ioOe <= 4'hF;
        end else begin
            ioOut <= 4'h0;
            ioOe <= 4'h0;
        end
    end

endmodule // qrp_quad_io_read_path

// >>> qrp_read_path_properties.sv
// Port checks for the quad read path.
`timescale 1ns/10ps

module qrp_read_path_properties #(
    parameter int QUAD_DUMMY_CLKS = 4
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic quadEnable,
    input wire logic wrapLoad,
    input wire logic [7:0] wrapByte,
    input wire logic softReset,
    input wire logic contModeReset,
    input wire logic contModeActive,
    input wire logic [2:0] wrapSettingBits,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic [3:0] ioOe,
    input wire logic [23:0] memAddr
);
    // ==========
    // Helper
    // ==========
    logic [1:0] quadOffCnt;
    // Idle link clocks with quad enable off; three of them outlast the sync lag.
    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            quadOffCnt <= 2'h0;
        end else begin
            quadOffCnt <= quadEnable ? 2'h0 : quadOffCnt + {1'b0, cs_n && quadOffCnt != 2'h3};
        end
    end
    // ==========
    // Assertions
    // ==========
    chk_wrap_reset_value: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(rst_n) |-> wrapSettingBits == 3'h1) else $error("wrap bits not at default");
    chk_wrap_load_bits: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wrapLoad && !softReset |=> wrapSettingBits == 3'($past(wrapByte) >> 4))
        else $error("wrap bits not loaded from bits six to four");
    chk_soft_wrap_default: assert property (@(posedge ref_clk) disable iff (!rst_n)
        softReset |=> wrapSettingBits == 3'h1) else $error("soft reset left wrap bits");
    chk_soft_keeps_mode: assert property (@(posedge ref_clk) disable iff (!rst_n)
        softReset && cs_n && !contModeReset |=> $stable(contModeActive))
        else $error("soft reset changed continuous mode");
    chk_oe_idle_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
        cs_n |-> ioOe == 4'h0) else $error("data lines driven while deselected");
    chk_oe_all_four: assert property (@(posedge sclk) disable iff (!rst_n)
        ioOe == 4'h0 || ioOe == 4'hF) else $error("data lines not driven together");
    chk_oe_holds_frame: assert property (@(posedge sclk) disable iff (!rst_n)
        !cs_n && !$past(cs_n) && $past(ioOe) == 4'hF |-> ioOe == 4'hF)
        else $error("output dropped inside the frame");
    chk_quad_off_gate: assert property (@(posedge sclk) disable iff (!rst_n)
        quadOffCnt == 2'h3 |-> ioOe == 4'h0) else $error("read answered without quad enable");
    chk_addr_step: assert property (@(posedge sclk) disable iff (!rst_n)
        !cs_n && !$past(cs_n) && $past(ioOe) == 4'hF && memAddr != $past(memAddr)
        |-> memAddr == $past(memAddr) + 24'h1 || ($past(memAddr) ^ memAddr) < 24'h40)
        else $error("read address jumped");
    cov_mode_skip: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(contModeActive));
    cov_wrap_load: cover property (@(posedge ref_clk) disable iff (!rst_n) wrapLoad);
    cov_data_out: cover property (@(posedge sclk) disable iff (!rst_n) ioOe == 4'hF);
endmodule // qrp_read_path_properties

bind qrp_quad_io_read_path qrp_read_path_properties #(.QUAD_DUMMY_CLKS(QUAD_DUMMY_CLKS))
    i_qrp_read_path_properties (.ref_clk(ref_clk), .rst_n(rst_n), .quadEnable(quadEnable),
    .wrapLoad(wrapLoad), .wrapByte(wrapByte), .softReset(softReset),
    .contModeReset(contModeReset), .contModeActive(contModeActive),
    .wrapSettingBits(wrapSettingBits), .sclk(sclk), .cs_n(cs_n), .ioOe(ioOe), .memAddr(memAddr));

// >>> qrp_host_model.sv
// Host controller model that clocks quad read frames onto the link.
`timescale 1ns/10ps

module qrp_host_model (
    output logic sclk,
    output logic cs_n,
    output logic [3:0] hostIo,
    input wire logic [3:0] ioOut,
    input wire logic [3:0] ioOe
);
    logic [7:0] got [0:15];
    logic [3:0] nib;
    logic oeSeen;

    // The link clock rests low and the chip is deselected outside frames.
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        hostIo = 4'h0;
        nib = 4'h0;
        oeSeen = 1'b0;
    end

    // One 12 ns link clock; the device nibble is taken just before the rising edge.
    task automatic tick(input logic [3:0] v);
        hostIo = v;
        #6;
        nib = ioOut;
        oeSeen = oeSeen | (ioOe != 4'h0);
        sclk = 1'b1;
        #6;
        sclk = 1'b0;
    endtask

    // Deselected clocks carry settings across to the link side before a frame.
    task automatic idle(input int k);
        repeat (k) tick(~hostIo);
    endtask

    task automatic frame(input bit op, input bit fw, input logic [7:0] code,
            input logic [23:0] a, input logic [7:0] m, input int dum, input int n);
        logic [3:0] hi;
        oeSeen = 1'b0;
        idle(3);
        cs_n = 1'b0;
        // opcode on one or four lines.
        for (int i = 0; i < 8 && op; i += (fw ? 4 : 1)) begin
            tick(fw ? code[7 - i -: 4] : {~hostIo[3:1], code[7 - i]});
        end
        for (int i = 5; i >= 0; i--) begin
            tick(a[4 * i +: 4]);
        end
        tick(m[7:4]);
        tick(m[3:0]);
        // released lines toggle so a stale level cannot pose as data.
        repeat (dum) tick(~hostIo);
        for (int i = 0; i < 2 * n; i++) begin
            tick(~hostIo);
            if (i % 2 == 1) got[i / 2] = {hi, nib};
            hi = nib;
        end
        cs_n = 1'b1;
    endtask
endmodule // qrp_host_model

// >>> tb.sv
// Self-checking bench for the quad read path with a host model on the link.
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errCount++; \
    $display("unexpected at %0t got %h exp %h", $time, g, e); end end

module tb;
    localparam int QD = 3;
    localparam logic [7:0] EB = qrp_pkg::OP_QUAD_READ;
    localparam logic [7:0] E7 = qrp_pkg::OP_WORD_READ;
    localparam logic [7:0] E3 = qrp_pkg::OP_OCTAL_READ;
    logic ref_clk;
    logic rst_n;
    logic quadEnable;
    logic fourWireMode;
    logic [3:0] pulses;
    logic [7:0] wrapByte;
    logic contModeActive;
    logic [2:0] wrapSettingBits;
    logic sclk;
    logic cs_n;
    logic [3:0] ioIn;
    logic [3:0] ioOut;
    logic [3:0] ioOe;
    logic [3:0] hostIo;
    logic [23:0] memAddr;
    logic [7:0] memData;
    logic [15:0] rnd;
    logic [7:0] expQ [$];
    int errCount;
    int comparisons;

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    function automatic logic [7:0] memByte(input int a);
        return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h5A;
    endfunction

    qrp_quad_io_read_path #(.QUAD_DUMMY_CLKS(QD)) i_qrp_quad_io_read_path (
        .ref_clk(ref_clk), .rst_n(rst_n), .quadEnable(quadEnable), .fourWireMode(fourWireMode),
        .wrapLoad(pulses[0]), .wrapByte(wrapByte), .readParamLoad(pulses[1]),
        .readParam(wrapByte[1:0]), .softReset(pulses[2]), .contModeReset(pulses[3]),
        .contModeActive(contModeActive), .wrapSettingBits(wrapSettingBits), .sclk(sclk),
        .cs_n(cs_n), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe), .memAddr(memAddr),
        .memData(memData));
    qrp_host_model i_qrp_host_model (.sclk(sclk), .cs_n(cs_n), .hostIo(hostIo), .ioOut(ioOut),
        .ioOe(ioOe));

    // Each line carries the device while it drives, the host otherwise; neighbours differ.
    assign ioIn = (ioOe & ioOut) | (~ioOe & hostIo);
    assign memData = memByte(memAddr);

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", comparisons, errCount);
        if (errCount == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // One pulse on a configuration strobe, then time for it to settle.
    task automatic pulse(input int k, input logic [7:0] v);
        @(posedge ref_clk);
        pulses <= 4'h1 << k;
        wrapByte <= v;
        @(posedge ref_clk);
        pulses <= 4'h0;
        repeat (4) @(posedge ref_clk);
    endtask

    // Reference read: a wrap of -1 means sequential with 24-bit rollover.
    task automatic rd(input bit op, input logic [7:0] code, input int a, input logic [7:0] m,
            input int dum, input int n, input int wrap, input bit ok);
        int p;
        int mask;
        logic [7:0] e;
        p = a;
        mask = (8 << (wrap & 3)) - 1;
        for (int i = 0; i < n; i++) begin
            expQ.push_back(memByte(p));
            p = wrap < 0 ? (p + 1) & 24'hFF_FFFF : (p & ~mask) | ((p + 1) & mask);
        end
        i_qrp_host_model.frame(op, fourWireMode, code, a[23:0], m, dum, n);
        `CHK(i_qrp_host_model.oeSeen, ok)
        for (int i = 0; i < n && ok; i++) begin
            e = expQ.pop_front();
            `CHK(i_qrp_host_model.got[i], e)
        end
        expQ.delete();
        repeat (6) @(posedge ref_clk);
    endtask

    // Main sequence: plain reads, wrap lengths, gating, continuous mode, four-wire mode.
    initial begin
        rst_n = 1'b0;
        quadEnable = 1'b0;
        fourWireMode = 1'b0;
        pulses = 4'h0;
        wrapByte = 8'h00;
        rnd = 16'h001E;
        errCount = 0;
        comparisons = 0;
        fork
            i_qrp_host_model.idle(3);
            repeat (6) @(posedge ref_clk);
        join
        rst_n <= 1'b1;
        quadEnable <= 1'b1;
        @(posedge ref_clk);
        `CHK(wrapSettingBits, 3'h1)
        rd(1, EB, {rnd, 8'h13}, 8'hFF, QD, 4, -1, 1);
        rd(1, E7, 24'hFF_FFFE, 8'h0F, 2, 4, -1, 1);
        rd(1, E3, 24'h00_0120, 8'h00, 0, 3, -1, 1);
        for (int w = 0; w < 4; w++) begin
            rnd = lfsr(rnd);
            pulse(0, {rnd[7], w[1:0], 1'b0, rnd[3:0]});
            `CHK(wrapSettingBits, {w[1:0], 1'b0})
            rd(1, w[0] ? E7 : EB, {rnd, 8'h00} | ((8 << w) - 2), 8'hFF,
                w[0] ? 2 : QD, 5, w, 1);
        end
        @(posedge ref_clk);
        quadEnable <= 1'b0;
        rd(1, EB, 24'h00_0040, 8'hFF, QD, 2, -1, 0);
        @(posedge ref_clk);
        quadEnable <= 1'b1;
        rnd = lfsr(rnd);
        rd(1, EB, {rnd, 8'h80}, {4'hA, rnd[3:0]}, QD, 2, 3, 1);
        `CHK(contModeActive, 1'b1)
        pulse(2, 8'h00);
        `CHK(contModeActive, 1'b1)
        `CHK(wrapSettingBits, 3'h1)
        rd(0, EB, 24'h12_3456, 8'hFF, QD, 3, -1, 1);
        `CHK(contModeActive, 1'b0)
        rd(1, EB, 24'h65_4321, 8'h00, QD, 2, -1, 1);
        rd(1, E3, 24'h00_0A30, 8'h2C, 0, 2, -1, 1);
        rd(0, E3, 24'h00_1B40, 8'h20, 0, 2, -1, 1);
        pulse(3, 8'h00);
        rd(1, E7, 24'h00_CC02, 8'h20, 2, 2, -1, 1);
        rd(0, E7, 24'h00_DD04, 8'hFF, 2, 2, -1, 1);
        @(posedge ref_clk);
        fourWireMode <= 1'b1;
        pulse(0, 8'h00);
        for (int s = 0; s < 4; s++) begin
            pulse(1, s[7:0]);
            rd(1, EB, 24'h00_21FE, 8'hFF, 2 * s, 4, -1, 1);
        end
        pulse(2, 8'h00);
        rd(1, EB, 24'h00_3306, 8'hA0, 0, 2, -1, 1);
        rd(0, EB, 24'h00_4408, 8'hFF, 0, 2, -1, 1);
        rd(1, E7, 24'h00_5500, 8'hFF, 2, 2, -1, 0);
        tally_and_finish();
    end

    // Twenty-two frames of under a hundred link clocks each finish well inside this span.
    initial begin
        #400000;
        errCount++;
        tally_and_finish();
    end
endmodule // tb
